// ---- rtl/dtd_axis_slope.sv ----
// Purpose: Slope criterion of one axis against the tap threshold
// Assumes: tick marks one update period; samples stable at tick
// Notes:   hit is a one-cycle pulse when the criterion becomes set
`timescale 1ns/1ps
`default_nettype none
module dtd_axis_slope
  import dtd_pkg::*;
(
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             tick,
  input  wire logic [ACC_W-1:0] acc_raw,
  input  wire logic [ACC_W-1:0] acc_filt,
  input  wire logic             filt_sel,
  input  wire logic [7:0]       step_n,
  input  wire logic [ACC_W-1:0] tap_slope_threshold,
  output logic                  hit,
  output logic                  slope_neg
);

  logic [ACC_W-1:0] ref_r;
  logic [7:0]       step_r;
  logic             crit_r;
  logic             hit_r;
  logic             neg_r;
  logic [ACC_W-1:0] cur;
  logic [ACC_W:0]   diff;
  logic [ACC_W:0]   mag;
  logic             eval;

  always_comb
  begin
    cur  = filt_sel ? acc_filt : acc_raw;
    diff = {cur[ACC_W-1], cur} - {ref_r[ACC_W-1], ref_r};
    mag  = diff[ACC_W] ? (ACC_W+1)'(-diff) : diff;
    eval = tick && (step_r == 8'h00);
  end

  // ----------------------------------------------------------------------
  // Slope over n update periods
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ref_r  <= '0;
      step_r <= 8'h00;
      crit_r <= 1'b0;
      hit_r  <= 1'b0;
      neg_r  <= 1'b0;
    end
    else
    begin
      hit_r <= 1'b0;
      if (eval)
      begin
        ref_r  <= cur;
        step_r <= step_n - 8'h01;
        crit_r <= mag > {1'b0, tap_slope_threshold};
        // Only the rising edge of the criterion counts as a slope
        hit_r  <= (mag > {1'b0, tap_slope_threshold}) && !crit_r;
        neg_r  <= diff[ACC_W];
      end
      else if (tick)
      begin
        // Shrinking n takes effect without waiting out a long old step
        step_r <= (step_r >= step_n) ? step_n - 8'h01 : step_r - 8'h01;
      end
    end
  end

  assign hit       = hit_r;
  assign slope_neg = neg_r;

endmodule
`default_nettype wire

// ---- rtl/dtd_pkg.sv ----
// Purpose: Shared constants, types and helpers of the double tap detector
// Assumes: 100 MHz hclk, 14-bit signed acceleration samples
// Notes:   Register offsets are byte addresses on a 32-bit AHB-Lite bus
package dtd_pkg;

  // ----------------------------------------------------------------------
  // Data and timing
  // ----------------------------------------------------------------------
  localparam int ACC_W          = 14;
  localparam int GAP_W          = 12;
  localparam int TICK_W         = 17;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int SHOCK_TIME_MS  = 50;
  localparam int SHOCK_UPDATES  = 120;
  // Update period in low noise mode, in hclk cycles (rounded down)
  localparam int UPD_CYCLES_LN  = (SHOCK_TIME_MS * 1000000) / (SHOCK_UPDATES * CLK_PERIOD_NS);
  localparam logic [GAP_W-1:0] SHOCK_LIMIT = GAP_W'(SHOCK_UPDATES);

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_THRESH   = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_INT_STAT = 8'h0c;
  localparam logic [7:0] ADDR_INT_MASK = 8'h10;
  localparam logic [7:0] ADDR_CMD      = 8'h14;

  localparam int CTRL_W         = 13;
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_AXIS_LSB  = 1;
  localparam int CTRL_FILT_BIT  = 4;
  localparam int CTRL_DUR_LSB   = 5;
  localparam int CTRL_LP_BIT    = 8;
  localparam int CTRL_BAND_LSB  = 9;
  localparam int CTRL_LATCH_BIT = 12;
  localparam logic [CTRL_W-1:0] CTRL_RESET   = 13'h0000;
  localparam logic [ACC_W-1:0]  THRESH_RESET = 14'h0100;
  localparam logic [2:0]        MASK_RESET   = 3'h0;

  localparam int STAT_FIRST_BIT = 0;
  localparam int STAT_SIGN_LSB  = 1;
  localparam int STAT_CNT_LSB   = 8;

  localparam int INT_TAP_BIT    = 0;
  localparam int INT_FIRST_BIT  = 1;
  localparam int INT_EXPIRE_BIT = 2;
  localparam int CMD_CLR_BIT    = 0;

  typedef enum logic {ST_IDLE, ST_PEND} dtd_state_t;

  // Slope step factor n = 1200 / bandwidth
  function automatic logic [7:0] dtd_step_n(input logic [2:0] filter_bandwidth_code);
    case (filter_bandwidth_code)
      3'h0:    dtd_step_n = 8'h78;
      3'h1:    dtd_step_n = 8'h3c;
      3'h2:    dtd_step_n = 8'h1e;
      3'h3:    dtd_step_n = 8'h10;
      3'h4:    dtd_step_n = 8'h08;
      3'h5:    dtd_step_n = 8'h04;
      3'h6:    dtd_step_n = 8'h02;
      default: dtd_step_n = 8'h01;
    endcase
  endfunction

  // Longest gap between the two slopes, in update periods
  function automatic logic [GAP_W-1:0] dtd_dur_updates(input logic [2:0] code);
    case (code)
      3'h0:    dtd_dur_updates = 12'h078;
      3'h1:    dtd_dur_updates = 12'h0b4;
      3'h2:    dtd_dur_updates = 12'h0f0;
      3'h3:    dtd_dur_updates = 12'h168;
      3'h4:    dtd_dur_updates = 12'h258;
      3'h5:    dtd_dur_updates = 12'h4b0;
      3'h6:    dtd_dur_updates = 12'h708;
      default: dtd_dur_updates = 12'h960;
    endcase
  endfunction

endpackage

// ---- rtl/dtd_tap_detector.sv ----
// Purpose: Double tap detector with AHB-Lite register slave
// Assumes: Acceleration buses come from logic on hclk; zero-wait slave
// Notes:   All gaps are counted in update periods made from hclk
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - The tap pin rises only while the tap interrupt enable is set.
// - A slope counts when its magnitude exceeds the unsigned tap threshold.
// - Each axis has an enable and only enabled axes feed the detector.
// - With filter select set, slopes use filtered data over n = 1200/bandwidth.
// - With filter select clear, slopes use raw data with n equal to one.
// - Duration codes 0 to 7 give 120,180,240,360,600,1200,1800,2400 updates.
// - Low power mode halves the update period so code 0 spans 25 ms instead of 50.
// - A second slope inside the shock blanking window raises nothing.
// - Each cycle with a rise of the tap threshold criterion on any enabled axis counts one slope.
// - The first slope sets first-tap, and a later one after 120 updates and before the limit fires.
// - First-tap clears on disable, on expiry of the duration, or on a fired tap.
// - Sign flags of the firing tap update only for enabled axes.
// - Enabled axes are OR-ed, so the two slopes may come from different axes.
// - A sequence starts with the first slope on any enabled axis when none is pending.
// - A clear command drops the tap pin only when latched and raised, else it is ignored.
module dtd_tap_detector
  import dtd_pkg::*;
#(
  parameter int unsigned UPD_CYCLES = UPD_CYCLES_LN
)
(
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic [31:0]           hrdata,
  input  wire logic [ACC_W-1:0] acc_raw_x,
  input  wire logic [ACC_W-1:0] acc_raw_y,
  input  wire logic [ACC_W-1:0] acc_raw_z,
  input  wire logic [ACC_W-1:0] acc_filt_x,
  input  wire logic [ACC_W-1:0] acc_filt_y,
  input  wire logic [ACC_W-1:0] acc_filt_z,
  output logic                  tap_int,
  output logic                  irq
);

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  logic              ap_valid_r;
  logic              ap_write_r;
  logic [7:0]        ap_addr_r;
  logic [31:0]       hrdata_r;
  logic [31:0]       rd_val;
  logic              addr_ok;
  logic              rd_take;
  logic              wr_en;

  logic [CTRL_W-1:0] ctrl_r;
  logic [ACC_W-1:0]  thresh_r;
  logic [2:0]        mask_r;
  logic [2:0]        int_stat_r;
  logic [2:0]        sign_r;
  logic [7:0]        slope_cnt_r;
  dtd_state_t        state_r;
  logic [GAP_W-1:0]  gap_r;
  logic              tap_int_r;

  assign addr_ok = hsel && htrans[1] && hready;
  assign rd_take = addr_ok && !hwrite;
  assign wr_en   = ap_valid_r && ap_write_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_valid_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_addr_r  <= 8'h00;
    end
    else
    begin
      ap_valid_r <= addr_ok;
      ap_write_r <= hwrite;
      ap_addr_r  <= haddr[7:0];
    end
  end

  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (haddr[31:8] == 24'h00_0000)
    begin
      case (haddr[7:0])
        ADDR_CTRL:     rd_val[CTRL_W-1:0] = ctrl_r;
        ADDR_THRESH:   rd_val[ACC_W-1:0]  = thresh_r;
        ADDR_STATUS:
        begin
          rd_val[STAT_FIRST_BIT]                 = (state_r == ST_PEND);
          rd_val[STAT_SIGN_LSB +: 3]             = sign_r;
          rd_val[STAT_CNT_LSB +: 8]              = slope_cnt_r;
        end
        ADDR_INT_STAT: rd_val[2:0] = int_stat_r;
        ADDR_INT_MASK: rd_val[2:0] = mask_r;
        default:       rd_val = 32'h0000_0000;
      endcase
    end
  end

  // Read data is sampled in the address phase, so a write just before
  // a read of the same register is seen one transfer late.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_r <= 32'h0000_0000;
    else if (rd_take)
      hrdata_r <= rd_val;
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_r   <= CTRL_RESET;
      thresh_r <= THRESH_RESET;
      mask_r   <= MASK_RESET;
    end
    else if (wr_en)
    begin
      case (ap_addr_r)
        ADDR_CTRL:     ctrl_r   <= hwdata[CTRL_W-1:0];
        ADDR_THRESH:   thresh_r <= hwdata[ACC_W-1:0];
        ADDR_INT_MASK: mask_r   <= hwdata[2:0];
        default:       ctrl_r   <= ctrl_r;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------------
  logic             tap_en;
  logic [2:0]       axis_en;
  logic             filt_sel;
  logic             low_power;
  logic             latch_en;
  logic [GAP_W-1:0] dur_lim;
  logic [7:0]       step_n;

  assign tap_en    = ctrl_r[CTRL_EN_BIT];
  assign axis_en   = ctrl_r[CTRL_AXIS_LSB +: 3];
  assign filt_sel  = ctrl_r[CTRL_FILT_BIT];
  assign low_power = ctrl_r[CTRL_LP_BIT];
  assign latch_en  = ctrl_r[CTRL_LATCH_BIT];
  assign dur_lim   = dtd_dur_updates(ctrl_r[CTRL_DUR_LSB +: 3]);
  assign step_n    = filt_sel ? dtd_step_n(ctrl_r[CTRL_BAND_LSB +: 3]) : 8'h01;

  // ----------------------------------------------------------------------
  // Update period
  // ----------------------------------------------------------------------
  logic [TICK_W-1:0] tick_cnt_r;
  logic [TICK_W-1:0] tick_lim;
  logic              tick;

  // Low power runs the update clock twice as fast
  assign tick_lim = low_power ? TICK_W'(UPD_CYCLES / 2) : TICK_W'(UPD_CYCLES);
  assign tick     = (tick_cnt_r >= tick_lim - TICK_W'(1));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tick_cnt_r <= '0;
    else if (tick)
      tick_cnt_r <= '0;
    else
      tick_cnt_r <= tick_cnt_r + TICK_W'(1);
  end

  // ----------------------------------------------------------------------
  // Axis slopes
  // ----------------------------------------------------------------------
  logic [ACC_W-1:0] acc_raw  [3];
  logic [ACC_W-1:0] acc_filt [3];
  logic [2:0]       axis_hit;
  logic [2:0]       axis_neg;
  logic             slope_any;

  assign acc_raw  = '{acc_raw_x, acc_raw_y, acc_raw_z};
  assign acc_filt = '{acc_filt_x, acc_filt_y, acc_filt_z};

  for (genvar i = 0; i < 3; i++)
  begin : g_axis
    dtd_axis_slope u_slope (
      .hclk                (hclk),
      .hresetn             (hresetn),
      .tick                (tick),
      .acc_raw             (acc_raw[i]),
      .acc_filt            (acc_filt[i]),
      .filt_sel            (filt_sel),
      .step_n              (step_n),
      .tap_slope_threshold (thresh_r),
      .hit                 (axis_hit[i]),
      .slope_neg           (axis_neg[i])
    );
  end

  assign slope_any = |(axis_hit & axis_en);

  // ----------------------------------------------------------------------
  // Tap sequence
  // ----------------------------------------------------------------------
  logic fire;
  logic start;
  logic expire;
  logic clr_ok;

  assign start  = tap_en && (state_r == ST_IDLE) && slope_any;
  assign fire   = tap_en && (state_r == ST_PEND) && slope_any
                  && (gap_r >= SHOCK_LIMIT) && (gap_r < dur_lim);
  assign expire = tap_en && (state_r == ST_PEND) && tick && !fire
                  && (gap_r >= dur_lim - GAP_W'(1));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r <= ST_IDLE;
      gap_r   <= '0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          gap_r <= '0;
          if (start)
            state_r <= ST_PEND;
        end
        ST_PEND:
        begin
          if (!tap_en || fire || expire)
            state_r <= ST_IDLE;
          else if (tick)
            gap_r <= gap_r + GAP_W'(1);
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      slope_cnt_r <= 8'h00;
    else if (slope_any)
      slope_cnt_r <= slope_cnt_r + 8'h01;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sign_r <= 3'h0;
    else if (fire)
      sign_r <= (sign_r & ~axis_en) | (axis_neg & axis_en);
  end

  // Clear command only counts against a latched, raised pin
  assign clr_ok = wr_en && (ap_addr_r == ADDR_CMD) && hwdata[CMD_CLR_BIT]
                  && latch_en && tap_int_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tap_int_r <= 1'b0;
    else if (fire)
      tap_int_r <= 1'b1;
    else if (clr_ok || (!latch_en && tick))
      tap_int_r <= 1'b0;
  end

  assign tap_int = tap_int_r;

  // ----------------------------------------------------------------------
  // Event status and interrupt line
  // ----------------------------------------------------------------------
  logic [2:0] ev;
  logic [2:0] rd_clr;

  assign ev     = {expire, start, fire};
  assign rd_clr = (rd_take && haddr == {24'h00_0000, ADDR_INT_STAT}) ? 3'h7 : 3'h0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      int_stat_r <= 3'h0;
    else
      int_stat_r <= (int_stat_r & ~rd_clr) | ev;
  end

  assign irq = |(int_stat_r & mask_r);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_pin_needs_en: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(tap_int_r) |-> $past(tap_en))
    else $error("tap pin rose while tap detection disabled");

  chk_shock_blank: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(tap_int_r) |-> $past(gap_r) >= SHOCK_LIMIT)
    else $error("tap fired inside shock window");

  chk_dur_limit: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(tap_int_r) |-> $past(gap_r) < $past(dur_lim))
    else $error("tap fired after duration limit");

  chk_first_start: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_r == ST_IDLE && tap_en && slope_any) |=> state_r == ST_PEND)
    else $error("first slope did not open a sequence");

  chk_first_clear: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (fire || !tap_en) |=> state_r == ST_IDLE)
    else $error("first-tap stayed set after fire or disable");

  chk_slope_count: assert property (
    @(posedge hclk) disable iff (!hresetn)
    slope_any |=> slope_cnt_r == $past(slope_cnt_r) + 8'h01)
    else $error("slope counter missed a slope");

  chk_sign_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !fire |=> $stable(sign_r))
    else $error("sign flags changed without a tap");

  chk_clear_latched: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (clr_ok && !fire) |=> !tap_int_r ##1 (!tap_int_r || $past(fire)))
    else $error("accepted clear did not drop the tap pin");

  chk_latch_holds: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (tap_int_r && latch_en && !clr_ok && $stable(latch_en)) |=> tap_int_r)
    else $error("latched tap pin dropped without a clear");

  chk_gap_window: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_r == ST_PEND && tap_en && tick && !fire && gap_r < dur_lim - GAP_W'(1))
      |=> state_r == ST_PEND && gap_r == $past(gap_r) + GAP_W'(1))
    else $error("gap counter did not advance inside window");

endmodule
`default_nettype wire

// ---- verification/dtd_host_model.sv ----
// Purpose: Host side that watches the tap interrupt pin
// Assumes: Pin sampled on hclk
// Notes:   Counts rises so lost or doubled pulses show up
`timescale 1ns/1ps
`default_nettype none
module dtd_host_model
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic tap_int,
  output var  int   n_rises
);
  logic tap_d_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tap_d_r <= 1'b0;
      n_rises <= 0;
    end
    else
    begin
      tap_d_r <= tap_int;
      if (tap_int && !tap_d_r)
        n_rises <= n_rises + 1;
    end
  end
endmodule
`default_nettype wire

// ---- verification/dtd_tap_detector_tb_top.sv ----
// Purpose: Register level tests of the double tap detector
// Assumes: UPD_CYCLES shortened to 20 hclk cycles
// Notes:   Tap gaps keep a margin of several updates to tick phase
`timescale 1ns/1ps
`default_nettype none
module dtd_tap_detector_tb_top
  import dtd_pkg::*;
;
  localparam int U = 20;
  logic             hclk    = 1'b0;
  logic             hresetn = 1'b0;
  logic             hsel    = 1'b0;
  logic [31:0]      haddr   = 32'h0;
  logic [1:0]       htrans  = 2'h0;
  logic             hwrite  = 1'b0;
  logic [2:0]       hsize   = 3'h2;
  logic [31:0]      hwdata  = 32'h0;
  wire logic        hready;
  logic             hreadyout;
  logic             hresp;
  logic [31:0]      hrdata;
  logic             tap_int;
  logic             irq;
  logic [ACC_W-1:0] raw [3];
  logic [ACC_W-1:0] filt [3];
  logic [31:0]      rd_v;
  int               n_rises;
  int               n_errors = 0;
  int               n_checks = 0;

  always #5 hclk = ~hclk;
  assign hready = hreadyout;

  dtd_tap_detector #(.UPD_CYCLES(U)) DUT
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .acc_raw_x(raw[0]), .acc_raw_y(raw[1]), .acc_raw_z(raw[2]),
    .acc_filt_x(filt[0]), .acc_filt_y(filt[1]), .acc_filt_z(filt[2]),
    .tap_int(tap_int), .irq(irq)
  );

  dtd_host_model HOST
  (
    .hclk(hclk), .hresetn(hresetn), .tap_int(tap_int), .n_rises(n_rises)
  );

  // ----------------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------------
  task automatic print_verdict();
    begin
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      n_checks++;
      if (got !== exp)
      begin
        n_errors++;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // Bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy();
    int k;
    begin
      k = 0;
      @(posedge hclk);
      while (hready !== 1'b1)
      begin
        k++;
        if (k > 50)
        begin
          n_errors++;
          print_verdict();
        end
        @(posedge hclk);
      end
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    begin
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      q = hrdata;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd_v);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    begin
      bus(1'b0, a, 32'h0, rd_v);
      chk(rd_v, exp);
    end
  endtask

  // One step of acceleration gives a single slope hit when n is one
  task automatic step(input logic f, input int ax, input int d);
    begin
      @(posedge hclk);
      if (f)
        filt[ax] <= filt[ax] + ACC_W'(d);
      else
        raw[ax] <= raw[ax] + ACC_W'(d);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n * U) @(posedge hclk);
  endtask

  task automatic wait_tap();
    int k;
    begin
      k = 0;
      while (tap_int !== 1'b1 && k < 4 * U)
      begin
        @(posedge hclk);
        k++;
      end
      n_checks++;
      if (tap_int !== 1'b1)
      begin
        n_errors++;
        $display("unexpected at %0t: got %h expected %h", $time, tap_int, 1'b1);
        print_verdict();
      end
    end
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    for (int i = 0; i < 3; i++)
    begin
      raw[i]  = '0;
      filt[i] = '0;
    end
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(ADDR_CTRL, 32'h0);
    rd_chk(ADDR_THRESH, 32'h100);
    rd_chk(ADDR_STATUS, 32'h0);
    rd_chk(ADDR_INT_STAT, 32'h0);
    rd_chk(ADDR_INT_MASK, 32'h0);
    rd_chk(8'h18, 32'h0);
    chk({30'h0, hresp, hreadyout}, 32'h1);
    wr(ADDR_THRESH, 32'h64);
    wr(ADDR_INT_MASK, 32'h1);
    // Enable, x and y, duration 180 updates, latched, raw data
    wr(ADDR_CTRL, 32'h1027);
    step(1'b0, 0, 200);
    ticks(3);
    rd_chk(ADDR_STATUS, 32'h0101);
    ticks(127);
    step(1'b0, 1, -200);
    wait_tap();
    ticks(4);
    chk({30'h0, tap_int, irq}, 32'h3);
    rd_chk(ADDR_STATUS, 32'h0204);
    rd_chk(ADDR_INT_STAT, 32'h3);
    chk({30'h0, tap_int, irq}, 32'h2);
    wr(ADDR_CMD, 32'h1);
    repeat (2) @(posedge hclk);
    chk({31'h0, tap_int}, 32'h0);
    // Second slope inside the shock window, then expiry
    step(1'b0, 0, 200);
    ticks(50);
    step(1'b0, 0, -200);
    ticks(3);
    chk({31'h0, tap_int}, 32'h0);
    rd_chk(ADDR_STATUS, 32'h0405);
    ticks(114);
    rd_chk(ADDR_STATUS, 32'h0405);
    ticks(20);
    rd_chk(ADDR_STATUS, 32'h0404);
    rd_chk(ADDR_INT_STAT, 32'h6);
    // Disable in mid-sequence
    step(1'b0, 0, 200);
    ticks(3);
    wr(ADDR_CTRL, 32'h1026);
    ticks(1);
    rd_chk(ADDR_STATUS, 32'h0504);
    // Only x enabled: y and z slopes are not seen
    wr(ADDR_CTRL, 32'h1023);
    step(1'b0, 2, 200);
    step(1'b0, 1, 200);
    ticks(3);
    rd_chk(ADDR_STATUS, 32'h0504);
    // Filtered x matches raw x, so switching the source adds no slope
    step(1'b1, 0, 400);
    // Filtered data with n of one, pulse mode
    wr(ADDR_CTRL, 32'h0e33);
    step(1'b0, 0, -200);
    ticks(3);
    rd_chk(ADDR_STATUS, 32'h0504);
    step(1'b1, 0, 200);
    ticks(3);
    rd_chk(ADDR_STATUS, 32'h0605);
    ticks(127);
    step(1'b1, 0, -200);
    wait_tap();
    // Clear in pulse mode is ignored: pin stays up until the next update
    wr(ADDR_CMD, 32'h1);
    chk({31'h0, tap_int}, 32'h1);
    ticks(2);
    chk({31'h0, tap_int}, 32'h0);
    rd_chk(ADDR_STATUS, 32'h0706);
    // Low power: updates twice as fast, so code 1 expires in half the time
    step(1'b0, 0, 200);
    wr(ADDR_CTRL, 32'h1123);
    step(1'b0, 0, 200);
    ticks(60);
    rd_chk(ADDR_STATUS, 32'h0807);
    ticks(40);
    rd_chk(ADDR_STATUS, 32'h0806);
    chk(32'(n_rises), 32'h2);
    print_verdict();
  end
endmodule
`default_nettype wire
